// *** verilog/ocd_cmd_decoder.sv ***
// command decoder core of the small display driver, with link and pixel ram
`timescale 1ns/10ps

module ocd_cmd_decoder
    import ocd_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // serial link
    input wire logic LINK_CS_N_I,
    input wire logic LINK_SCK_I,
    input wire logic LINK_SDI_I,
    output logic LINK_SDO_O,
    output logic LINK_SDO_OE_O,
    // addressing
    output logic [7:0] COL_O,
    output logic [3:0] PAGE_O,
    output logic [5:0] START_LINE_O,
    output logic [5:0] OFFSET_O,
    output logic RMW_O,
    // display control
    output logic [7:0] CONTRAST_O,
    output logic SEG_REMAP_O,
    output logic COM_REMAP_O,
    output logic ALL_ON_O,
    output logic INVERSE_O,
    output logic DISP_ON_O,
    output logic ICON_O,
    // panel timing and drive
    output logic [6:0] MUX_RATIO_O,
    output logic [9:0] FRAME_DIV_O,
    output logic LOW_BIAS_O,
    output logic LOW_POWER_O,
    output logic [3:0] PRECHARGE_O,
    output logic PRECHARGE_LOW_O,
    output logic FULL_CURRENT_O,
    // status
    output logic [7:0] STATUS_O
);
    import ocd_pkg::*;

    // true for opcodes that take an argument byte
    function automatic logic is_two(input logic [7:0] op);
        is_two = (op == OP_CONTRAST) || (op == OP_MUX) || (op == OP_FRAME)
              || (op == OP_BIAS) || (op == OP_OFFSET) || (op == OP_LOW_PWR)
              || (op == OP_PRECHG) || (op == OP_CURRENT);
    endfunction

    // multiplex ratio from its stored argument
    function automatic logic [6:0] mux_n(input logic [5:0] arg);
        mux_n = {1'b0, arg} + 7'h02;
    endfunction

    // oscillator divide factor for a frame code and ratio
    function automatic logic [9:0] frame_div(input logic [4:0] code, input logic [6:0] n);
        case (code)
            FRC_DIV4: frame_div = {3'b000, n} * 10'h004;
            FRC_DIV6: frame_div = {3'b000, n} * 10'h006;
            FRC_DIV8: frame_div = {3'b000, n} * 10'h008;
            default: frame_div = 10'h000;
        endcase
    endfunction

    ocd_frame_if f ();   // byte carrier between link and core

    // serial link receiver and return path
    ocd_link_rx u_rx (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .cs_n_i(LINK_CS_N_I),
        .sck_i(LINK_SCK_I),
        .sdi_i(LINK_SDI_I),
        .f(f.rx)
    );

    ocd_link_tx u_tx (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .f(f.tx),
        .sdo_o(LINK_SDO_O),
        .sdo_oe_o(LINK_SDO_OE_O)
    );

    ocd_cfg_t cfg_q, cfg_d;              // controller state
    ocd_dec_state_t state_q, state_d;    // opcode or argument expected
    logic [7:0] arg_op_q;                // opcode waiting for its argument
    logic [INIT_CNT_W-1:0] init_cnt_q;   // initialisation cycles left
    logic [7:0] ram [0:4095];            // display_pixel_ram, page by column
    logic [7:0] status_q;
    logic [6:0] mux_q;
    logic [9:0] fdiv_q;
    logic tx_load_q;
    logic [7:0] tx_byte_q;

    // byte classification
    wire [7:0] b = f.rx_byte;
    wire cmd_stb = f.byte_stb & ~f.rw & ~f.dc;
    wire dat_wr = f.byte_stb & ~f.rw & f.dc;
    wire rd_stb = f.hdr_stb & f.rw;
    wire dat_rd = rd_stb & f.dc;
    wire op_stb = cmd_stb && state_q == ST_OPCODE;
    wire arg_stb = cmd_stb && state_q == ST_ARG;
    wire [11:0] ram_addr = {cfg_q.page, cfg_q.col};
    wire [7:0] ram_rd = ram[ram_addr];

    // single byte command decode
    wire op_col_lo = op_stb && b[7:4] == OPN_COL_LO;
    wire op_col_hi = op_stb && b[7:4] == OPN_COL_HI;
    wire op_start = op_stb && b[7:6] == OPP_START;
    wire op_page = op_stb && b[7:4] == OPN_PAGE && b[3:0] <= PAGE_MAX;
    wire op_com = op_stb && b[7:4] == OPN_COM_DIR;
    wire op_seg = op_stb && {b[7:1], 1'b0} == OP_SEG_REMAP;
    wire op_all = op_stb && {b[7:1], 1'b0} == OP_ALL_ON;
    wire op_inv = op_stb && {b[7:1], 1'b0} == OP_INVERSE;
    wire op_disp = op_stb && {b[7:1], 1'b0} == OP_DISP;
    wire op_icon = op_stb && {b[7:1], 1'b0} == OP_ICON;
    wire op_rmw_in = op_stb && b == OP_RMW_ENTER;
    wire op_rmw_out = op_stb && b == OP_RMW_EXIT;
    wire op_soft = op_stb && b == OP_SOFT_RST;
    wire op_nop = op_stb && b == OP_NOP;
    wire op_two = op_stb && is_two(b);

    // argument decode for the pending two byte opcode
    wire a_con = arg_stb && arg_op_q == OP_CONTRAST;
    wire a_mux = arg_stb && arg_op_q == OP_MUX;
    wire a_frm = arg_stb && arg_op_q == OP_FRAME && b[4:0] >= FRC_DIV4 && b[4:0] <= FRC_DIV8;
    wire a_bias = arg_stb && arg_op_q == OP_BIAS;
    wire a_off = arg_stb && arg_op_q == OP_OFFSET;
    wire a_lpw = arg_stb && arg_op_q == OP_LOW_PWR;
    wire a_pre = arg_stb && arg_op_q == OP_PRECHG;
    wire a_cur = arg_stb && arg_op_q == OP_CURRENT;
    // precharge period codes 0 and 1 are refused and leave the period as it was
    wire pre_ok = b[7:4] != PRE_BAD0 && b[7:4] != PRE_BAD1;
    wire init_busy = init_cnt_q != '0;

    // next controller state; soft reset wins over every other change
    always_comb begin
        cfg_d = cfg_q;
        if (op_soft) begin
            cfg_d = CFG_POR;
        end else begin
            if (op_col_lo) cfg_d.col[3:0] = b[3:0];
            if (op_col_hi) cfg_d.col[7:4] = b[3:0];
            if (op_start) cfg_d.start = b[5:0];
            if (op_page) cfg_d.page = b[3:0];
            if (op_com) cfg_d.com_remap = b[3];
            if (op_seg) cfg_d.seg_remap = b[0];
            if (op_all) cfg_d.all_on = b[0];
            if (op_inv) cfg_d.inverse = b[0];
            if (op_disp) cfg_d.disp_on = b[0];
            if (op_icon) cfg_d.icon = b[0];
            // entering saves the column; a second entry keeps the first save
            if (op_rmw_in && !cfg_q.rmw) begin
                cfg_d.rmw = 1'b1;
                cfg_d.rmw_col = cfg_q.col;
            end
            if (op_rmw_out && cfg_q.rmw) begin
                cfg_d.rmw = 1'b0;
                cfg_d.col = cfg_q.rmw_col;
            end
            if (a_con) cfg_d.contrast = b;
            if (a_mux) cfg_d.mux_arg = b[5:0];
            if (a_frm) cfg_d.frame_code = b[4:0];
            // only the two documented bias patterns change the level
            if (a_bias && b[3] && !b[5] && !b[0]) cfg_d.low_bias = 1'b0;
            if (a_bias && !b[3] && b[5] && b[0]) cfg_d.low_bias = 1'b1;
            if (a_off) cfg_d.offset = b[5:0];
            if (a_lpw && !b[2] && !b[0]) cfg_d.low_power = 1'b0;
            if (a_lpw && b[2] && b[0]) cfg_d.low_power = 1'b1;
            if (a_pre && pre_ok) cfg_d.pre_period = b[7:4];
            if (a_pre && b[3:0] == PRE_NORM_CODE) cfg_d.pre_low = 1'b0;
            if (a_pre && b[3:0] == PRE_LOW_CODE) cfg_d.pre_low = 1'b1;
            if (a_cur) cfg_d.full_cur = b[1];
            // data writes always advance; reads advance unless in rmw mode
            if (dat_wr) cfg_d.col = cfg_q.col + 8'h01;
            if (dat_rd && !cfg_q.rmw) cfg_d.col = cfg_q.col + 8'h01;
        end
    end

    // opcode / argument sequencing
    always_comb begin
        state_d = state_q;
        if (op_two) state_d = ST_ARG;
        else if (arg_stb) state_d = ST_OPCODE;
    end

    // controller state registers
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            cfg_q <= CFG_POR;
            state_q <= ST_OPCODE;
        end else begin
            cfg_q <= cfg_d;
            state_q <= state_d;
        end
    end

    // opcode held while its argument is awaited
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) arg_op_q <= 8'h00;
        else if (op_two) arg_op_q <= b;
    end

    // initialisation timer after either reset; commands are still accepted meanwhile
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || op_soft) init_cnt_q <= INIT_CNT_W'(INIT_CYCLES);
        else if (init_busy) init_cnt_q <= init_cnt_q - 1'b1;
    end

    // pixel ram write, no reset: contents are undefined after power-up
    always_ff @(posedge CORE_CLK_I) begin
        if (dat_wr) ram[ram_addr] <= b;
    end

    // read answers: status on command reads, ram byte on data reads
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            tx_load_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end else begin
            tx_load_q <= rd_stb;
            if (rd_stb) tx_byte_q <= f.dc ? ram_rd : status_q;
        end
    end

    // derived outputs, registered from the next state so they track cfg_q
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            status_q <= {1'b1, 1'b1, 1'b1, 1'b1, 4'h0};
            mux_q <= mux_n(MUX_ARG_POR);
            fdiv_q <= frame_div(FRC_DIV6, mux_n(MUX_ARG_POR));
        end else begin
            status_q <= {init_busy, ~cfg_d.seg_remap, ~cfg_d.disp_on, init_busy, 4'h0};
            mux_q <= mux_n(cfg_d.mux_arg);
            fdiv_q <= frame_div(cfg_d.frame_code, mux_n(cfg_d.mux_arg));
        end
    end

    assign f.tx_load = tx_load_q;
    assign f.tx_byte = tx_byte_q;

    // output map, each straight from a flop
    assign COL_O = cfg_q.col;
    assign PAGE_O = cfg_q.page;
    assign START_LINE_O = cfg_q.start;
    assign OFFSET_O = cfg_q.offset;
    assign RMW_O = cfg_q.rmw;
    assign CONTRAST_O = cfg_q.contrast;
    assign SEG_REMAP_O = cfg_q.seg_remap;
    assign COM_REMAP_O = cfg_q.com_remap;
    assign ALL_ON_O = cfg_q.all_on;
    assign INVERSE_O = cfg_q.inverse;
    assign DISP_ON_O = cfg_q.disp_on;
    assign ICON_O = cfg_q.icon;
    assign MUX_RATIO_O = mux_q;
    assign FRAME_DIV_O = fdiv_q;
    assign LOW_BIAS_O = cfg_q.low_bias;
    assign LOW_POWER_O = cfg_q.low_power;
    assign PRECHARGE_O = cfg_q.pre_period;
    assign PRECHARGE_LOW_O = cfg_q.pre_low;
    assign FULL_CURRENT_O = cfg_q.full_cur;
    assign STATUS_O = status_q;

    default clocking dc_cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_soft;
        op_soft;
    endsequence
    sequence s_rmw_exit;
        op_rmw_out && RMW_O;
    endsequence

    chk_col_lo_load: assert property (op_col_lo |=> COL_O[3:0] == $past(b[3:0]))
        else $error("column low nibble not loaded");
    chk_col_hi_load: assert property (op_col_hi |=> COL_O[7:4] == $past(b[3:0]))
        else $error("column high nibble not loaded");
    chk_start_line: assert property (op_start |=> START_LINE_O == $past(b[5:0]))
        else $error("start line not loaded");
    chk_contrast_arg: assert property (a_con |=> CONTRAST_O == $past(b))
        else $error("contrast argument not taken");
    chk_disp_status: assert property (op_disp |=> DISP_ON_O == $past(b[0])
        ##1 STATUS_O[5] == !DISP_ON_O)
        else $error("display on bit or status wrong");
    chk_data_advance: assert property (dat_wr |=> COL_O == $past(COL_O) + 8'h01)
        else $error("column did not advance on write");
    chk_rmw_hold: assert property (dat_rd && RMW_O |=> COL_O == $past(COL_O))
        else $error("column moved on read in rmw mode");
    chk_rmw_restore: assert property (s_rmw_exit |=> !RMW_O && COL_O == $past(cfg_q.rmw_col))
        else $error("column not restored on rmw exit");
    chk_mux_ratio: assert property (a_mux |=> ##1 MUX_RATIO_O == $past(b[5:0], 2) + 7'h02)
        else $error("multiplex ratio wrong");
    chk_soft_reset: assert property (s_soft |=> CONTRAST_O == CONTRAST_POR && !DISP_ON_O
        ##1 STATUS_O[4] && STATUS_O[7])
        else $error("soft reset did not reinitialise");
    chk_two_byte_arg: assert property (op_two |=> state_q == ST_ARG)
        else $error("argument byte not expected");
    chk_frame_div4: assert property (a_frm && b[4:0] == FRC_DIV4
        |=> ##1 FRAME_DIV_O == {3'b000, MUX_RATIO_O} * 10'h004)
        else $error("frame divide wrong");
endmodule // ocd_cmd_decoder

// *** verilog/ocd_pkg.sv ***
// constants and types shared by the display command decoder
package ocd_pkg;

    // timing: initialisation after hardware or software reset
    localparam int CLK_PERIOD_NS = 5;
    localparam int INIT_TIME_NS = 100;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W = 8;

    // link frame: read/write bit, then per byte a data/command bit and 8 data bits
    localparam logic [3:0] FRM_RW_SLOT = 4'h0;
    localparam logic [3:0] FRM_DC_SLOT = 4'h1;
    localparam logic [3:0] FRM_LAST_SLOT = 4'h9;

    // single byte opcodes (compared after masking, except rmw, soft reset and nop)
    localparam logic [3:0] OPN_COL_LO = 4'h0;
    localparam logic [3:0] OPN_COL_HI = 4'h1;
    localparam logic [3:0] OPN_PAGE = 4'hB;
    localparam logic [3:0] OPN_COM_DIR = 4'hC;
    localparam logic [1:0] OPP_START = 2'h1;
    localparam logic [7:0] OP_SEG_REMAP = 8'hA0;
    localparam logic [7:0] OP_ALL_ON = 8'hA4;
    localparam logic [7:0] OP_INVERSE = 8'hA6;
    localparam logic [7:0] OP_DISP = 8'hAE;
    localparam logic [7:0] OP_ICON = 8'hD0;
    localparam logic [7:0] OP_RMW_ENTER = 8'hE0;
    localparam logic [7:0] OP_SOFT_RST = 8'hE2;
    localparam logic [7:0] OP_NOP = 8'hE3;
    localparam logic [7:0] OP_RMW_EXIT = 8'hEE;
    // two byte opcodes
    localparam logic [7:0] OP_CONTRAST = 8'h81;
    localparam logic [7:0] OP_MUX = 8'hA8;
    localparam logic [7:0] OP_FRAME = 8'hAA;
    localparam logic [7:0] OP_BIAS = 8'hAB;
    localparam logic [7:0] OP_OFFSET = 8'hD3;
    localparam logic [7:0] OP_LOW_PWR = 8'hD8;
    localparam logic [7:0] OP_PRECHG = 8'hD9;
    localparam logic [7:0] OP_CURRENT = 8'hDA;

    // frame rate codes, page limit and precharge codes
    localparam logic [4:0] FRC_DIV4 = 5'h01;
    localparam logic [4:0] FRC_DIV6 = 5'h02;
    localparam logic [4:0] FRC_DIV8 = 5'h03;
    localparam logic [3:0] PAGE_MAX = 4'h8;
    localparam logic [3:0] PRE_LOW_CODE = 4'h3;
    localparam logic [3:0] PRE_NORM_CODE = 4'h8;
    localparam logic [3:0] PRE_BAD0 = 4'h0;
    localparam logic [3:0] PRE_BAD1 = 4'h1;

    // decoder state
    typedef enum logic {ST_OPCODE, ST_ARG} ocd_dec_state_t;

    // controller state held by the decoder
    typedef struct packed {
        logic [7:0] col;
        logic [3:0] page;
        logic [5:0] start;
        logic [7:0] contrast;
        logic seg_remap;
        logic all_on;
        logic inverse;
        logic disp_on;
        logic com_remap;
        logic rmw;
        logic [7:0] rmw_col;
        logic [5:0] mux_arg;
        logic [4:0] frame_code;
        logic low_bias;
        logic icon;
        logic [5:0] offset;
        logic low_power;
        logic [3:0] pre_period;
        logic pre_low;
        logic full_cur;
    } ocd_cfg_t;

    // power-on values
    localparam logic [7:0] CONTRAST_POR = 8'h80;
    localparam logic [5:0] MUX_ARG_POR = 6'h3F;
    localparam ocd_cfg_t CFG_POR = '{col: 8'h00, page: 4'h0, start: 6'h00,
        contrast: CONTRAST_POR, seg_remap: 1'b0, all_on: 1'b0, inverse: 1'b0,
        disp_on: 1'b0, com_remap: 1'b0, rmw: 1'b0, rmw_col: 8'h00,
        mux_arg: MUX_ARG_POR, frame_code: FRC_DIV6, low_bias: 1'b0, icon: 1'b0,
        offset: 6'h00, low_power: 1'b0, pre_period: PRE_NORM_CODE,
        pre_low: 1'b0, full_cur: 1'b0};

endpackage

// *** verilog/ocd_frame_if.sv ***
// byte-level carrier between the link receiver, transmitter and decoder core
`timescale 1ns/10ps
interface ocd_frame_if;
    logic cs_act;          // frame in progress
    logic fall_stb;        // link clock falling edge seen
    logic hdr_stb;         // data/command bit just taken
    logic rw;              // frame is a read
    logic dc;              // current byte is display data
    logic byte_stb;        // eight data bits taken
    logic [7:0] rx_byte;   // received byte
    logic tx_load;         // byte to shift out on the next falls
    logic [7:0] tx_byte;   // byte to return
    modport rx (output cs_act, fall_stb, hdr_stb, rw, dc, byte_stb, rx_byte);
    modport core (input hdr_stb, rw, dc, byte_stb, rx_byte, output tx_load, tx_byte);
    modport tx (input cs_act, fall_stb, tx_load, tx_byte);
endinterface

// *** verilog/ocd_link_rx.sv ***
// link receiver: synchronises the serial pins and frames bits into bytes
`timescale 1ns/10ps
module ocd_link_rx
    import ocd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    // byte side
    ocd_frame_if.rx f
);
    logic [2:0] s1_q;     // first synchroniser stage: cs_n, sck, sdi
    logic [2:0] s2_q;     // second stage, only reader of s1_q
    logic sck_prev_q;     // previous synchronised link clock
    logic [3:0] slot_q;   // bit slot within the frame
    logic [7:0] sh_q;     // incoming shift register
    logic hdr_q, byte_q, fall_q, rw_q, dc_q;
    wire cs_act = ~s2_q[2];
    wire rise = s2_q[1] & ~sck_prev_q;
    wire fall = ~s2_q[1] & sck_prev_q;
    wire take = cs_act & rise;

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clk_i) begin
        s1_q <= {cs_n_i, sck_i, sdi_i};
        s2_q <= s1_q;
        sck_prev_q <= s2_q[1];
    end

    // slot counter: after the last data bit the next byte's data/command bit follows
    always_ff @(posedge clk_i) begin
        if (rst_i || !cs_act) begin
            slot_q <= FRM_RW_SLOT;
        end else if (take) begin
            slot_q <= (slot_q == FRM_LAST_SLOT) ? FRM_DC_SLOT : slot_q + 4'h1;
        end
    end

    // sample bits and raise one-cycle strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {hdr_q, byte_q, fall_q, rw_q, dc_q, sh_q} <= '0;
        end else begin
            hdr_q <= take && slot_q == FRM_DC_SLOT;
            byte_q <= take && slot_q == FRM_LAST_SLOT;
            fall_q <= cs_act & fall;
            if (take && slot_q == FRM_RW_SLOT) rw_q <= s2_q[0];
            if (take && slot_q == FRM_DC_SLOT) dc_q <= s2_q[0];
            if (take) sh_q <= {sh_q[6:0], s2_q[0]};
        end
    end

    assign f.cs_act = cs_act;
    assign f.fall_stb = fall_q;
    assign f.hdr_stb = hdr_q;
    assign f.byte_stb = byte_q;
    assign f.rw = rw_q;
    assign f.dc = dc_q;
    assign f.rx_byte = sh_q;
endmodule // ocd_link_rx

// *** verilog/ocd_link_tx.sv ***
// link transmitter: returns a byte msb first, changing on link clock falls
`timescale 1ns/10ps
module ocd_link_tx (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // byte side
    ocd_frame_if.tx f,
    // pin side
    output logic sdo_o,
    output logic sdo_oe_o
);
    logic [7:0] sh_q;   // outgoing shift register
    logic pend_q;       // byte waits for the next fall
    logic oe_q;

    // load on the fall after the request so bit 7 is stable for the host's next rise
    always_ff @(posedge clk_i) begin
        if (rst_i || !f.cs_act) begin
            sh_q <= 8'h00;
            pend_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            if (f.tx_load) pend_q <= 1'b1;
            if (f.fall_stb && pend_q) begin
                sh_q <= f.tx_byte;
                pend_q <= 1'b0;
                oe_q <= 1'b1;
            end else if (f.fall_stb) begin
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    assign sdo_o = sh_q[7];
    assign sdo_oe_o = oe_q;
endmodule // ocd_link_tx

// *** testbench/ocd_host_model.sv ***
// host-side model that drives serial link frames toward the decoder
`timescale 1ns/10ps
module ocd_host_model (
    // pacing clock
    input wire logic clk_i,
    // link pins
    output logic cs_n_o,
    output logic sck_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic [7:0] rd_q; // last eight bits sampled from the device
    // link idles deselected with its clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
        rd_q = 8'h00;
    end
    // one bit: data set while the clock is low, both sides sample on the rise
    task automatic bit_out(input logic b);
        sdi_o = b;
        repeat (16) @(negedge clk_i);
        sck_o = 1'b1;
        rd_q = {rd_q[6:0], sdo_i};
        repeat (16) @(negedge clk_i);
        sck_o = 1'b0;
    endtask
    // whole frame: direction bit, then per byte its kind bit and eight bits msb first
    task automatic frame(input logic rw, input logic dc, input logic [15:0] w, input int n);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        bit_out(rw);
        for (int i = n - 1; i >= 0; i--) begin
            bit_out(dc);
            for (int b = 7; b >= 0; b--) begin
                bit_out(w[8*i+b]);
            end
        end
        cs_n_o = 1'b1;
        // released data line must not keep showing its last value
        sdi_o = ~sdi_o;
        repeat (16) @(negedge clk_i);
    endtask
endmodule // ocd_host_model

// *** testbench/ocd_cmd_decoder_tb.sv ***
// self-checking bench for the display command decoder
`timescale 1ns/10ps
module ocd_cmd_decoder_tb;
    import ocd_pkg::*;
    // one case: command word, byte count, watched output, expected value
    typedef struct {logic [15:0] cmd; int n; int sel; logic [9:0] exp;} ocd_row_t;
    logic CORE_CLK_I, RST_I, LINK_CS_N_I, LINK_SCK_I, LINK_SDI_I, LINK_SDO_O, LINK_SDO_OE_O;
    logic [7:0] COL_O, CONTRAST_O, STATUS_O;
    logic [3:0] PAGE_O, PRECHARGE_O;
    logic [5:0] START_LINE_O, OFFSET_O;
    logic [6:0] MUX_RATIO_O;
    logic [9:0] FRAME_DIV_O;
    logic RMW_O, SEG_REMAP_O, COM_REMAP_O, ALL_ON_O, INVERSE_O, DISP_ON_O, ICON_O;
    logic LOW_BIAS_O, LOW_POWER_O, PRECHARGE_LOW_O, FULL_CURRENT_O;
    logic [9:0] ov [20]; // outputs gathered so rows can name one by index
    int fails = 0;
    int checks_done = 0;
    // output enable as the host saw it at the last link clock rise
    logic oe_at_rise = 1'b0;
    always @(posedge LINK_SCK_I) oe_at_rise <= LINK_SDO_OE_O;
    // power-on values in the order of ov
    logic [9:0] por [20] = '{10'h000, 10'h000, 10'h000, 10'h080, 10'h000, 10'h000, 10'h000,
        10'h000, 10'h000, 10'h000, 10'h041, 10'h186, 10'h000, 10'h000, 10'h008, 10'h000,
        10'h000, 10'h000, 10'h000, 10'h0F0};
    ocd_row_t rows [] = '{
        '{16'h0005, 1, 0, 10'h005}, '{16'h0013, 1, 0, 10'h035},
        '{16'h007F, 1, 2, 10'h03F}, '{16'h81FF, 2, 3, 10'h0FF},
        '{16'h00A1, 1, 4, 10'h001}, '{16'h00A5, 1, 5, 10'h001},
        '{16'h00A7, 1, 6, 10'h001}, '{16'h00AF, 1, 7, 10'h001},
        '{16'h00B8, 1, 1, 10'h008}, '{16'h00B9, 1, 1, 10'h008},
        '{16'h00C8, 1, 8, 10'h001}, '{16'h00D1, 1, 9, 10'h001},
        '{16'hA80F, 2, 10, 10'h011}, '{16'hAA41, 2, 11, 10'h044},
        '{16'hAA43, 2, 11, 10'h088}, '{16'hABA1, 2, 12, 10'h001},
        '{16'hAB88, 2, 12, 10'h000}, '{16'hD805, 2, 13, 10'h001},
        '{16'hD9F3, 2, 15, 10'h001}, '{16'hD923, 2, 14, 10'h002},
        '{16'hDA12, 2, 16, 10'h001}, '{16'hD33F, 2, 17, 10'h03F},
        '{16'h00E3, 1, 3, 10'h0FF}, '{16'h00A4, 1, 5, 10'h000},
        '{16'h00AE, 1, 7, 10'h000}, '{16'h00A5, 1, 5, 10'h001}};
    assign ov = '{10'(COL_O), 10'(PAGE_O), 10'(START_LINE_O), 10'(CONTRAST_O),
        10'(SEG_REMAP_O), 10'(ALL_ON_O), 10'(INVERSE_O), 10'(DISP_ON_O), 10'(COM_REMAP_O),
        10'(ICON_O), 10'(MUX_RATIO_O), FRAME_DIV_O, 10'(LOW_BIAS_O), 10'(LOW_POWER_O),
        10'(PRECHARGE_O), 10'(PRECHARGE_LOW_O), 10'(FULL_CURRENT_O), 10'(OFFSET_O),
        10'(RMW_O), 10'(STATUS_O)};
    ocd_cmd_decoder dut (.*);
    ocd_host_model host (.clk_i(CORE_CLK_I), .cs_n_o(LINK_CS_N_I), .sck_o(LINK_SCK_I),
        .sdi_o(LINK_SDI_I), .sdo_i(LINK_SDO_O));
    // compare one value and count it
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // 200 MHz core clock
    initial begin
        CORE_CLK_I = 1'b0;
        forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
    end
    // hang guard: the whole run is far shorter than this
    initial begin
        repeat (100000) @(posedge CORE_CLK_I);
        fails++;
        end_sim();
    end
    // main sequence
    initial begin
        RST_I = 1'b1;
        repeat (10) @(negedge CORE_CLK_I);
        RST_I = 1'b0;
        foreach (por[i]) chk(ov[i], por[i]);
        repeat (30) @(negedge CORE_CLK_I);
        chk(STATUS_O, 10'h060);
        foreach (rows[i]) begin
            host.frame(1'b0, 1'b0, rows[i].cmd, rows[i].n);
            chk(ov[rows[i].sel], rows[i].exp);
        end
        host.frame(1'b0, 1'b1, 16'h1234, 2);
        chk(COL_O, 10'h037);
        host.frame(1'b0, 1'b0, 16'h00E0, 1);
        chk(RMW_O, 10'h001);
        host.frame(1'b0, 1'b1, 16'h0055, 1);
        host.frame(1'b1, 1'b1, 16'h0000, 1);
        chk(COL_O, 10'h038);
        host.frame(1'b0, 1'b0, 16'h00EE, 1);
        chk(COL_O, 10'h037);
        chk(RMW_O, 10'h000);
        chk(oe_at_rise, 10'h000);
        // read back the byte written in rmw mode; outside rmw the read advances
        host.frame(1'b1, 1'b1, 16'h0000, 1);
        chk(host.rd_q, 10'h055);
        chk(oe_at_rise, 10'h001);
        chk(LINK_SDO_OE_O, 10'h000);
        chk(COL_O, 10'h038);
        host.frame(1'b1, 1'b0, 16'h0000, 1);
        chk(host.rd_q, 10'h020);
        host.frame(1'b0, 1'b0, 16'h00E2, 1);
        chk(CONTRAST_O, 10'h080);
        // soft reset: every setting back to power-on, init already over
        foreach (por[i]) if (i < 19) chk(ov[i], por[i]);
        chk(STATUS_O, 10'h060);
        // hardware reset in mid-run over a changed contrast
        host.frame(1'b0, 1'b0, 16'h8112, 2);
        chk(CONTRAST_O, 10'h012);
        RST_I = 1'b1;
        repeat (4) @(negedge CORE_CLK_I);
        RST_I = 1'b0;
        chk(CONTRAST_O, 10'h080);
        chk(STATUS_O, 10'h0F0);
        end_sim();
    end
endmodule // ocd_cmd_decoder_tb
